// [cpu_core_register_file_tb_top.sv]
// testbench for the core register file
`timescale 1ns/100ps
module cpu_core_register_file_tb_top;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  wire [11:0] awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [3:0]  wstrb;
  wire [1:0]  bresp, rresp;
  wire        awvalid, awready, wvalid, wready, bvalid, bready;
  wire        arvalid, arready, rvalid, rready, bsel;
  wire [15:0] asp;
  wire [19:0] pc, vtb;
  integer     miscompares = 0;
  integer     comparisons = 0;
  integer     i;
  reg  [31:0] d;
  reg  [1:0]  r;
  always #10 aclk = ~aclk;
  crf_core dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .active_stack_pointer(asp), .program_counter_out(pc),
    .vector_table_base_out(vtb), .bank_select(bsel));
  crf_axi_master mst_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  task report_and_stop;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wchk(input [11:0] a, input [31:0] v, input [3:0] s);
    mst_u.wr(a, v, s, r);
    chk("bresp", {30'h0, r}, (a > 12'h050) ? 32'h2 : 32'h0);
  endtask
  task rchk(input [11:0] a, input [31:0] e);
    mst_u.rd(a, d, r);
    chk("rresp", {30'h0, r}, (a > 12'h050) ? 32'h2 : 32'h0);
    chk("rdata", d, e);
  endtask
  function [31:0] msk(input integer k);
    msk = (k == 7 || k == 8) ? 32'hFFFFF : (k == 12) ? 32'h7FF : 32'hFFFF;
  endfunction
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares = miscompares + 1;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 21; i = i + 1)
      rchk(12'(4 * i), 32'h0);
    for (i = 0; i < 13; i = i + 1)
      wchk(12'(4 * i), 32'h7ECB9D00 | i, 4'hF);
    for (i = 0; i < 13; i = i + 1)
      rchk(12'(4 * i), (32'h7ECB9D00 | i) & msk(i));
    repeat (2) @(posedge aclk);
    chk("asp", {16'h0, asp}, 32'h9D0A);
    chk("pc", {12'h0, pc}, 32'hB9D08);
    chk("vtb", {12'h0, vtb}, 32'hB9D07);
    rchk(12'h034, 32'h9D0A);
    wchk(12'h030, 32'h0C0, 4'hF);
    repeat (2) @(posedge aclk);
    chk("bank", {31'h0, bsel}, 32'h1);
    chk("asp", {16'h0, asp}, 32'h9D09);
    rchk(12'h000, 32'h0);
    wchk(12'h034, 32'h4321, 4'hF);
    rchk(12'h024, 32'h4321);
    wchk(12'h030, 32'h080, 4'hF);
    rchk(12'h000, 32'h9D00);
    wchk(12'h038, 32'hEE, 4'h1);
    wchk(12'h03C, 32'h77, 4'h1);
    rchk(12'h000, 32'hEE77);
    wchk(12'h044, 32'hC3, 4'h1);
    rchk(12'h040, 32'h9D);
    wchk(12'h004, 32'hFFFF, 4'h2);
    rchk(12'h004, 32'hFFC3);
    mst_u.slow = 1'b1;
    wchk(12'h048, 32'hCAFEF00D, 4'hF);
    rchk(12'h008, 32'hCAFE);
    mst_u.slow = 1'b0;
    rchk(12'h000, 32'hF00D);
    wchk(12'h04C, 32'h12345678, 4'hF);
    rchk(12'h00C, 32'h1234);
    rchk(12'h04C, 32'h12345678);
    rchk(12'h048, 32'hCAFEF00D);
    rchk(12'h03C, 32'h0D);
    wchk(12'h050, 32'h89ABCDEF, 4'hF);
    rchk(12'h014, 32'h89AB);
    rchk(12'h050, 32'h89ABCDEF);
    wchk(12'h100, 32'h1, 4'hF);
    rchk(12'h100, 32'h0);
    report_and_stop;
  end
endmodule

// [crf_axi_master.sv]
// axi4-lite master standing in for the datapath side
`timescale 1ns/100ps
module crf_axi_master (
  // clock
  input  wire        aclk,
  // write side
  output reg  [11:0] awaddr,
  output reg         awvalid,
  input  wire        awready,
  output reg  [31:0] wdata,
  output reg  [3:0]  wstrb,
  output reg         wvalid,
  input  wire        wready,
  input  wire [1:0]  bresp,
  input  wire        bvalid,
  output reg         bready,
  // read side
  output reg  [11:0] araddr,
  output reg         arvalid,
  input  wire        arready,
  input  wire [31:0] rdata,
  input  wire [1:0]  rresp,
  input  wire        rvalid,
  output reg         rready
);
  reg slow;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = 51'h0;
    {araddr, arvalid, rready, slow} = 15'h0;
  end
  task wr(input [11:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !slow;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    join
    do @(posedge aclk); while (!bvalid);
    if (slow) begin
      bready <= 1'b1;
      @(posedge aclk);
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  task rd(input [11:0] a, output [31:0] d, output [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slow;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge aclk); while (!rvalid);
    if (slow) begin
      rready <= 1'b1;
      @(posedge aclk);
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// [crf_core.v]
// core register file with two banks, stack select and an axi4-lite slave
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "crf_defines.vh"
module crf_core (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // write address channel
  input  wire [11:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // write data channel
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // write response channel
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // read address channel
  input  wire [11:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // read data channel
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // datapath view
  output reg  [15:0] active_stack_pointer,
  output reg  [19:0] program_counter_out,
  output reg  [19:0] vector_table_base_out,
  output reg         bank_select
);
  // write address and data capture
  reg         aw_held_reg;
  reg  [11:0] aw_addr_reg;
  reg         w_held_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  wire        wr_go;
  wire        rd_go;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // bank select and stack select from the flag register
  reg  [10:0] processor_flags_reg;
  wire        bank = processor_flags_reg[`CRF_FLG_BANK];
  wire        ssel = processor_flags_reg[`CRF_FLG_STKSEL];

  // write decode
  wire [11:0] wa = aw_addr_reg;
  wire        s0 = w_strb_reg[0];
  wire        s1 = w_strb_reg[1];
  wire        s2 = w_strb_reg[2];
  wire        s3 = w_strb_reg[3];
  wire [15:0] wlo = w_data_reg[15:0];
  wire [15:0] whi = w_data_reg[31:16];
  wire [15:0] bh = {w_data_reg[7:0], 8'h00};
  wire [15:0] bl = {8'h00, w_data_reg[7:0]};
  reg  [7:0]  hi_en;
  reg  [7:0]  lo_en;
  reg         map_hit;

  // index: 0..3 data, 4..5 address, 6 frame base, 7 static base
  always @* begin
    hi_en = 8'h00;
    lo_en = 8'h00;
    map_hit = 1'b1;
    case (wa)
      `CRF_OFF_DATA0: begin
        hi_en[0] = s1;
        lo_en[0] = s0;
      end
      `CRF_OFF_DATA1: begin
        hi_en[1] = s1;
        lo_en[1] = s0;
      end
      `CRF_OFF_DATA2: begin
        hi_en[2] = s1;
        lo_en[2] = s0;
      end
      `CRF_OFF_DATA3: begin
        hi_en[3] = s1;
        lo_en[3] = s0;
      end
      `CRF_OFF_ADDR0: begin
        hi_en[4] = s1;
        lo_en[4] = s0;
      end
      `CRF_OFF_ADDR1: begin
        hi_en[5] = s1;
        lo_en[5] = s0;
      end
      `CRF_OFF_FB: begin
        hi_en[6] = s1;
        lo_en[6] = s0;
      end
      `CRF_OFF_SBASE: begin
        hi_en[7] = s1;
        lo_en[7] = s0;
      end
      `CRF_OFF_B0H:   hi_en[0] = s0;
      `CRF_OFF_B0L:   lo_en[0] = s0;
      `CRF_OFF_B1H:   hi_en[1] = s0;
      `CRF_OFF_B1L:   lo_en[1] = s0;
      `CRF_OFF_PAIRLO: begin
        hi_en[0] = s1;
        lo_en[0] = s0;
        hi_en[2] = s3;
        lo_en[2] = s2;
      end
      `CRF_OFF_PAIRHI: begin
        hi_en[1] = s1;
        lo_en[1] = s0;
        hi_en[3] = s3;
        lo_en[3] = s2;
      end
      `CRF_OFF_APAIR: begin
        hi_en[4] = s1;
        lo_en[4] = s0;
        hi_en[5] = s3;
        lo_en[5] = s2;
      end
      `CRF_OFF_VTB, `CRF_OFF_PCNT, `CRF_OFF_USTK, `CRF_OFF_ISTK,
      `CRF_OFF_FLAGS, `CRF_OFF_ASTK: map_hit = 1'b1;
      default: map_hit = 1'b0;
    endcase
    if (!wr_go) begin
      hi_en = 8'h00;
      lo_en = 8'h00;
    end
  end

  // source word for each bank register on a write
  wire        is_byte_hi = (wa == `CRF_OFF_B0H) || (wa == `CRF_OFF_B1H);
  wire        is_byte_lo = (wa == `CRF_OFF_B0L) || (wa == `CRF_OFF_B1L);
  wire        is_pair = (wa == `CRF_OFF_PAIRLO) || (wa == `CRF_OFF_PAIRHI) ||
                        (wa == `CRF_OFF_APAIR);
  wire [15:0] lo_src = is_byte_hi ? bh : (is_byte_lo ? bl : wlo);
  wire [15:0] hi_src = is_pair ? whi : lo_src;

  // two banks of eight 16-bit registers
  wire [15:0] bank_q [0:15];
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_bank
      wire sel = (g / 8) == bank;
      wire up = ((g % 8) == 2) || ((g % 8) == 3) || ((g % 8) == 5);
      crf_word_reg u_reg (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_hi   (sel && hi_en[g % 8]),
        .wr_lo   (sel && lo_en[g % 8]),
        .wdata   (up ? hi_src : lo_src),
        .q_reg   (bank_q[g])
      );
    end
  endgenerate

  wire [3:0]  bb = {bank, 3'h0};
  wire [15:0] d0 = bank_q[bb];
  wire [15:0] d1 = bank_q[bb + 4'h1];
  wire [15:0] d2 = bank_q[bb + 4'h2];
  wire [15:0] d3 = bank_q[bb + 4'h3];
  wire [15:0] a0 = bank_q[bb + 4'h4];
  wire [15:0] a1 = bank_q[bb + 4'h5];
  wire [15:0] fbq = bank_q[bb + 4'h6];
  wire [15:0] sbq = bank_q[bb + 4'h7];

  // shared registers
  reg  [19:0] vector_table_base_reg;
  reg  [19:0] program_counter_reg;
  reg  [15:0] user_stack_pointer_reg;
  reg  [15:0] interrupt_stack_pointer_reg;
  wire        astk_w = wr_go && (wa == `CRF_OFF_ASTK);

  always @(posedge aclk) begin
    if (!aresetn) begin
      vector_table_base_reg       <= `CRF_RST20;
      program_counter_reg         <= `CRF_RST20;
      user_stack_pointer_reg      <= `CRF_RST16;
      interrupt_stack_pointer_reg <= `CRF_RST16;
      processor_flags_reg         <= `CRF_RSTFLG;
    end else if (wr_go) begin
      if (wa == `CRF_OFF_VTB) begin
        if (s0) vector_table_base_reg[7:0] <= w_data_reg[7:0];
        if (s1) vector_table_base_reg[15:8] <= w_data_reg[15:8];
        if (s2) vector_table_base_reg[19:16] <= w_data_reg[19:16];
      end
      if (wa == `CRF_OFF_PCNT) begin
        if (s0) program_counter_reg[7:0] <= w_data_reg[7:0];
        if (s1) program_counter_reg[15:8] <= w_data_reg[15:8];
        if (s2) program_counter_reg[19:16] <= w_data_reg[19:16];
      end
      if ((wa == `CRF_OFF_USTK) || (astk_w && ssel)) begin
        if (s0) user_stack_pointer_reg[7:0] <= wlo[7:0];
        if (s1) user_stack_pointer_reg[15:8] <= wlo[15:8];
      end
      if ((wa == `CRF_OFF_ISTK) || (astk_w && !ssel)) begin
        if (s0) interrupt_stack_pointer_reg[7:0] <= wlo[7:0];
        if (s1) interrupt_stack_pointer_reg[15:8] <= wlo[15:8];
      end
      if (wa == `CRF_OFF_FLAGS) begin
        if (s0) processor_flags_reg[7:0] <= w_data_reg[7:0];
        if (s1) processor_flags_reg[10:8] <= w_data_reg[10:8];
      end
    end
  end

  // active stack pointer selection
  wire [15:0] sp_sel = ssel ? user_stack_pointer_reg
                            : interrupt_stack_pointer_reg;

  // read mux
  reg  [31:0] rd_word;
  reg         rd_hit;
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `CRF_OFF_DATA0:  rd_word = {16'h0000, d0};
      `CRF_OFF_DATA1:  rd_word = {16'h0000, d1};
      `CRF_OFF_DATA2:  rd_word = {16'h0000, d2};
      `CRF_OFF_DATA3:  rd_word = {16'h0000, d3};
      `CRF_OFF_ADDR0:  rd_word = {16'h0000, a0};
      `CRF_OFF_ADDR1:  rd_word = {16'h0000, a1};
      `CRF_OFF_FB:     rd_word = {16'h0000, fbq};
      `CRF_OFF_VTB:    rd_word = {12'h000, vector_table_base_reg};
      `CRF_OFF_PCNT:   rd_word = {12'h000, program_counter_reg};
      `CRF_OFF_USTK:   rd_word = {16'h0000, user_stack_pointer_reg};
      `CRF_OFF_ISTK:   rd_word = {16'h0000, interrupt_stack_pointer_reg};
      `CRF_OFF_SBASE:  rd_word = {16'h0000, sbq};
      `CRF_OFF_FLAGS:  rd_word = {21'h000000, processor_flags_reg};
      `CRF_OFF_ASTK:   rd_word = {16'h0000, sp_sel};
      `CRF_OFF_B0H:    rd_word = {24'h000000, d0[15:8]};
      `CRF_OFF_B0L:    rd_word = {24'h000000, d0[7:0]};
      `CRF_OFF_B1H:    rd_word = {24'h000000, d1[15:8]};
      `CRF_OFF_B1L:    rd_word = {24'h000000, d1[7:0]};
      `CRF_OFF_PAIRLO: rd_word = {d2, d0};
      `CRF_OFF_PAIRHI: rd_word = {d3, d1};
      `CRF_OFF_APAIR:  rd_word = {a1, a0};
      default: begin
        rd_word = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // responses and datapath outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CRF_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `CRF_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      active_stack_pointer  <= `CRF_RST16;
      program_counter_out   <= `CRF_RST20;
      vector_table_base_out <= `CRF_RST20;
      bank_select           <= 1'b0;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= map_hit ? `CRF_RESP_OKAY : `CRF_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? `CRF_RESP_OKAY : `CRF_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      active_stack_pointer  <= sp_sel;
      program_counter_out   <= program_counter_reg;
      vector_table_base_out <= vector_table_base_reg;
      bank_select           <= bank;
    end
  end
endmodule

// [crf_core_props.sv]
// assertions on the register file bus and datapath outputs
`timescale 1ns/100ps
module crf_props (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // bus
  input wire [11:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // datapath view
  input wire [15:0] active_stack_pointer,
  input wire        bank_select
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence flag_wr;
    wr_take ##0 (s_axi_awaddr == 12'h030 && s_axi_wstrb[0]);
  endsequence
  property bank_follow;
    flag_wr |=> ##2 (bank_select == $past(s_axi_wdata[6], 3));
  endproperty
  AST_RD_ANS: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_WR_ANS: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer timing wrong");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  AST_B_REFUSE: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  AST_RST: assert property (disable iff (1'b0) !aresetn
    |=> !s_axi_bvalid && !s_axi_rvalid) else $error("valid after reset");
  AST_BANK_SET: assert property (bank_follow)
    else $error("bank select not taken from flags");
  AST_BANK_STABLE: assert property (!$stable(bank_select)
    |-> $past(s_axi_bvalid)) else $error("bank select moved alone");
  AST_ASP_STABLE: assert property (!$stable(active_stack_pointer)
    |-> $past(s_axi_bvalid)) else $error("stack pointer moved alone");
endmodule
bind crf_core crf_props props_u (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .active_stack_pointer, .bank_select);

// [crf_defines.vh]
// register map, field positions and reset values of the core register file
`ifndef CRF_DEFINES_VH
`define CRF_DEFINES_VH
// register byte offsets on the bus
`define CRF_OFF_DATA0     12'h000
`define CRF_OFF_DATA1     12'h004
`define CRF_OFF_DATA2     12'h008
`define CRF_OFF_DATA3     12'h00C
`define CRF_OFF_ADDR0     12'h010
`define CRF_OFF_ADDR1     12'h014
`define CRF_OFF_FB        12'h018
`define CRF_OFF_VTB       12'h01C
`define CRF_OFF_PCNT      12'h020
`define CRF_OFF_USTK      12'h024
`define CRF_OFF_ISTK      12'h028
`define CRF_OFF_SBASE     12'h02C
`define CRF_OFF_FLAGS     12'h030
`define CRF_OFF_ASTK      12'h034
`define CRF_OFF_B0H       12'h038
`define CRF_OFF_B0L       12'h03C
`define CRF_OFF_B1H       12'h040
`define CRF_OFF_B1L       12'h044
`define CRF_OFF_PAIRLO    12'h048
`define CRF_OFF_PAIRHI    12'h04C
`define CRF_OFF_APAIR     12'h050
// widths
`define CRF_W16           16
`define CRF_W20           20
`define CRF_WFLG          11
// flag fields
`define CRF_FLG_BANK      6
`define CRF_FLG_STKSEL    7
// reset values
`define CRF_RST16         16'h0000
`define CRF_RST20         20'h00000
`define CRF_RSTFLG        11'h000
// bus responses
`define CRF_RESP_OKAY     2'h0
`define CRF_RESP_SLVERR   2'h2
`endif

// [crf_word_reg.v]
// one 16-bit register with two byte write enables
`timescale 1ns/100ps
`include "crf_defines.vh"
module crf_word_reg (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // write side
  input  wire        wr_hi,
  input  wire        wr_lo,
  input  wire [15:0] wdata,
  // state
  output reg  [15:0] q_reg
);
  always @(posedge aclk) begin
    if (!aresetn) begin
      q_reg <= `CRF_RST16;
    end else begin
      if (wr_hi) begin
        q_reg[15:8] <= wdata[15:8];
      end
      if (wr_lo) begin
        q_reg[7:0] <= wdata[7:0];
      end
    end
  end
endmodule
